// file: cmt_pkg.sv
// Shared constants and helpers for the CAN mailbox transmit control block
package cmt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] OFF_DIRECTION  = 8'h00;
  localparam logic [7:0] OFF_REQUEST    = 8'h04;
  localparam logic [7:0] OFF_CANCEL     = 8'h08;
  localparam logic [7:0] OFF_DONE       = 8'h0c;
  localparam logic [7:0] OFF_ABORT      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          MAILBOXES      = 16;
  localparam int          IDX_W          = 4;
  localparam logic [15:0] MAILBOX_USED   = 16'hfffe;
  localparam logic        DIR_RSV_VALUE  = 1'b1;
  localparam logic        FLAG_RSV_VALUE = 1'b0;
  localparam logic        DIR_TRANSMIT   = 1'b0;
  localparam logic [15:0] DIRECTION_RST  = 16'h0000;
  localparam logic [15:0] VECTOR_RST     = 16'h0000;
  localparam int          IRQ_BITS       = 2;
  localparam int          IRQ_TX_DONE    = 0;
  localparam int          IRQ_ABORT      = 1;
  localparam logic [1:0]  IRQ_RST        = 2'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mailbox vector to register layout: 7..1 high, 15..8 low
  function automatic logic [15:0] mb_to_reg(input logic [15:0] mb, input logic rsv);
    mb_to_reg = {mb[7:1], rsv, mb[15:8]};
  endfunction : mb_to_reg

  // Register layout to mailbox vector, mailbox 0 empty
  function automatic logic [15:0] reg_to_mb(input logic [15:0] r);
    reg_to_mb = {r[7:0], r[15:9], 1'b0};
  endfunction : reg_to_mb

  // Event pulse with index to a mailbox vector
  function automatic logic [15:0] onehot(input logic hit, input logic [3:0] idx);
    onehot = hit ? ((16'h0001 << idx) & MAILBOX_USED) : 16'h0000;
  endfunction : onehot

endpackage : cmt_pkg

// file: cmt_tx_arbiter.sv
// Fixed priority pick of the mailbox that enters bus arbitration
`timescale 1ns/1ps
module cmt_tx_arbiter #(
  parameter int N     = 16,
  parameter int IDX_W = 4
) (
  input  wire logic [N-1:0]     pending,
  output logic                  found,
  output logic [IDX_W-1:0]      index
);

  // ----------------------------------------------------------------
  // Lowest mailbox number wins
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule : cmt_tx_arbiter

// file: cmt_mailbox_tx_control.sv
// CAN mailbox direction and transmit control registers with AXI4-Lite access
//
// Summary of operation
// - A direction bit of 0 makes its mailbox transmit, 1 receive, and all transmit after reset.
// - Register bits 15..9 map mailboxes 7..1, bits 7..0 map mailboxes 15..8, bit 8 no mailbox.
// - Bit 8 of the direction register reads 1 always and software writes it as 1.
// - Bit 8 of request, cancel and done registers reads 0 and software writes it as 0.
// - Writing 1 to the request bit of a transmit mailbox puts it into transmit wait for bus arbitration.
// - A request bit clears when its message is sent or its cancellation completes.
// - Writing 1 to a cancel bit cancels that mailbox's waiting message.
// - A cancel bit clears together with its request, when its message is sent or its cancellation completes.
// - A done flag sets on error-free transmission and clears when software writes 1.
// - An abort flag sets on error-free cancellation and clears when software writes 1.
`timescale 1ns/1ps
module cmt_mailbox_tx_control #(
  parameter int MAILBOXES = cmt_pkg::MAILBOXES,
  parameter int IDX_W     = cmt_pkg::IDX_W
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [cmt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [cmt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      engine_tx_done,
  input  wire logic [IDX_W-1:0]          engine_tx_done_mailbox,
  input  wire logic                      engine_cancel_done,
  input  wire logic [IDX_W-1:0]          engine_cancel_done_mailbox,
  output logic                           tx_select_valid,
  output logic [IDX_W-1:0]               tx_select_mailbox,
  output logic [MAILBOXES-1:0]           cancel_pending,
  output logic [MAILBOXES-1:0]           receive_enable,
  output logic                           irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]                  direction;
  logic [15:0]                  transmit_request;
  logic [15:0]                  transmit_cancel;
  logic [15:0]                  transmit_done_flags;
  logic [15:0]                  abort_done_flags;
  logic [cmt_pkg::IRQ_BITS-1:0] irq_status;
  logic [cmt_pkg::IRQ_BITS-1:0] irq_mask;

  logic                         aw_held;
  logic                         w_held;
  logic [cmt_pkg::ADDR_W-1:0]   aw_addr_q;
  logic [15:0]                  w_data_q;
  logic [1:0]                   w_strb_q;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;
  logic next_aw_held;
  logic next_w_held;

  assign aw_fire      = s_axi_awvalid & s_axi_awready;
  assign w_fire       = s_axi_wvalid & s_axi_wready;
  assign ar_fire      = s_axi_arvalid & s_axi_arready;
  assign wr_do        = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = wr_do ? 1'b0 : (aw_held | aw_fire);
  assign next_w_held  = wr_do ? 1'b0 : (w_held | w_fire);

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 16'h0000;
      w_strb_q      <= 2'h0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata[15:0];
        w_strb_q <= s_axi_wstrb[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic [15:0] byte_mask;
  logic [15:0] wr_ones_mb;
  logic [15:0] wr_mask_mb;
  logic        wr_dir;
  logic        wr_req;
  logic        wr_cancel;
  logic        wr_done;
  logic        wr_abort;
  logic        wr_imask;
  logic        wr_hit;

  assign byte_mask  = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_ones_mb = cmt_pkg::reg_to_mb(w_data_q & byte_mask);
  assign wr_mask_mb = cmt_pkg::reg_to_mb(byte_mask);
  assign wr_dir     = wr_do & (aw_addr_q == cmt_pkg::OFF_DIRECTION);
  assign wr_req     = wr_do & (aw_addr_q == cmt_pkg::OFF_REQUEST);
  assign wr_cancel  = wr_do & (aw_addr_q == cmt_pkg::OFF_CANCEL);
  assign wr_done    = wr_do & (aw_addr_q == cmt_pkg::OFF_DONE);
  assign wr_abort   = wr_do & (aw_addr_q == cmt_pkg::OFF_ABORT);
  assign wr_imask   = wr_do & (aw_addr_q == cmt_pkg::OFF_IRQ_MASK);
  assign wr_hit     = wr_dir | wr_req | wr_cancel | wr_done | wr_abort | wr_imask
                      | (wr_do & (aw_addr_q == cmt_pkg::OFF_IRQ_STATUS));

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cmt_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Engine events
  // ----------------------------------------------------------------
  logic [15:0] sent_vec;
  logic [15:0] cancelled_vec;

  assign sent_vec      = cmt_pkg::onehot(engine_tx_done, engine_tx_done_mailbox);
  assign cancelled_vec = cmt_pkg::onehot(engine_cancel_done, engine_cancel_done_mailbox);

  // ----------------------------------------------------------------
  // Direction register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction <= cmt_pkg::DIRECTION_RST;
    end else if (wr_dir) begin
      direction <= ((direction & ~wr_mask_mb) | wr_ones_mb) & cmt_pkg::MAILBOX_USED;
    end
  end

  // ----------------------------------------------------------------
  // Transmit request
  // ----------------------------------------------------------------
  logic [15:0] req_set;

  // Receive mailboxes take no request; a new request wins over a clear
  assign req_set = wr_req ? (wr_ones_mb & ~direction) : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_request <= cmt_pkg::VECTOR_RST;
    end else begin
      transmit_request <= (transmit_request & ~(sent_vec | cancelled_vec)) | req_set;
    end
  end

  // ----------------------------------------------------------------
  // Transmit cancel
  // ----------------------------------------------------------------
  logic [15:0] cancel_set;

  // A request that ends in this cycle takes no new cancel
  assign cancel_set = wr_cancel ? (wr_ones_mb & transmit_request & ~(sent_vec | cancelled_vec))
                      : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_cancel <= cmt_pkg::VECTOR_RST;
    end else begin
      // Cleared together with the request it cancelled
      transmit_cancel <= (transmit_cancel & ~(cancelled_vec | sent_vec)) | cancel_set;
    end
  end

  // ----------------------------------------------------------------
  // Done and abort flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_done_flags <= cmt_pkg::VECTOR_RST;
    end else begin
      transmit_done_flags <= (transmit_done_flags & ~(wr_done ? wr_ones_mb : 16'h0000))
                             | sent_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_done_flags <= cmt_pkg::VECTOR_RST;
    end else begin
      abort_done_flags <= (abort_done_flags & ~(wr_abort ? wr_ones_mb : 16'h0000))
                          | cancelled_vec;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  logic                         rd_status;
  logic [cmt_pkg::IRQ_BITS-1:0] irq_events;

  assign rd_status  = ar_fire & (s_axi_araddr == cmt_pkg::OFF_IRQ_STATUS);
  assign irq_events = {(|cancelled_vec), (|sent_vec)};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= cmt_pkg::IRQ_RST;
    end else begin
      irq_status <= (rd_status ? cmt_pkg::IRQ_RST : irq_status) | irq_events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= cmt_pkg::IRQ_RST;
    end else if (wr_imask & w_strb_q[0]) begin
      irq_mask <= w_data_q[cmt_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      cmt_pkg::OFF_DIRECTION:
        rd_word = cmt_pkg::mb_to_reg(direction, cmt_pkg::DIR_RSV_VALUE);
      cmt_pkg::OFF_REQUEST:
        rd_word = cmt_pkg::mb_to_reg(transmit_request, cmt_pkg::FLAG_RSV_VALUE);
      cmt_pkg::OFF_CANCEL:
        rd_word = cmt_pkg::mb_to_reg(transmit_cancel, cmt_pkg::FLAG_RSV_VALUE);
      cmt_pkg::OFF_DONE:
        rd_word = cmt_pkg::mb_to_reg(transmit_done_flags, cmt_pkg::FLAG_RSV_VALUE);
      cmt_pkg::OFF_ABORT:
        rd_word = cmt_pkg::mb_to_reg(abort_done_flags, cmt_pkg::FLAG_RSV_VALUE);
      cmt_pkg::OFF_IRQ_STATUS:
        rd_word = {14'h0000, irq_status};
      cmt_pkg::OFF_IRQ_MASK:
        rd_word = {14'h0000, irq_mask};
      default:
        rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cmt_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_word};
      s_axi_rresp   <= rd_hit ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mailbox selection toward the protocol engine
  // ----------------------------------------------------------------
  logic             pick_found;
  logic [IDX_W-1:0] pick_index;
  logic [15:0]      waiting;

  assign waiting = transmit_request & ~transmit_cancel & ~direction;

  cmt_tx_arbiter #(
    .N     (MAILBOXES),
    .IDX_W (IDX_W)
  ) u_arbiter (
    .pending (waiting),
    .found   (pick_found),
    .index   (pick_index)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_select_valid   <= 1'b0;
      tx_select_mailbox <= '0;
      cancel_pending    <= '0;
      receive_enable    <= '0;
    end else begin
      tx_select_valid   <= pick_found;
      tx_select_mailbox <= pick_index;
      cancel_pending    <= transmit_cancel;
      receive_enable    <= direction;
    end
  end

endmodule : cmt_mailbox_tx_control

// file: cmt_mailbox_tx_control_props.sv
// Port checker for the CAN mailbox transmit control block
`timescale 1ns/1ps
module cmt_mailbox_tx_control_props #(
  parameter int MAILBOXES = 16,
  parameter int IDX_W     = 4
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 engine_tx_done,
  input wire logic [IDX_W-1:0]     engine_tx_done_mailbox,
  input wire logic                 engine_cancel_done,
  input wire logic [IDX_W-1:0]     engine_cancel_done_mailbox,
  input wire logic                 tx_select_valid,
  input wire logic [IDX_W-1:0]     tx_select_mailbox,
  input wire logic [MAILBOXES-1:0] cancel_pending,
  input wire logic [MAILBOXES-1:0] receive_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  chk_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after a taken address");
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer did not follow the address");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // ----------------------------------------------------------------
  // Mailbox state
  // ----------------------------------------------------------------
  chk_mb0_unused: assert property (!receive_enable[0] && !cancel_pending[0])
    else $error("mailbox zero shows state");
  chk_sel_nonzero: assert property (tx_select_valid |-> tx_select_mailbox != 4'h0)
    else $error("mailbox zero selected");
  chk_sel_uncancel: assert property (tx_select_valid |-> !cancel_pending[tx_select_mailbox])
    else $error("cancelled mailbox selected");
  chk_sent_dropped: assert property (engine_tx_done && tx_select_valid &&
      engine_tx_done_mailbox == tx_select_mailbox |-> ##2
      (!tx_select_valid || tx_select_mailbox != $past(engine_tx_done_mailbox, 2)))
    else $error("sent mailbox still waiting");
  chk_cancel_cleared: assert property (engine_cancel_done &&
      cancel_pending[engine_cancel_done_mailbox] |-> ##2
      !cancel_pending[$past(engine_cancel_done_mailbox, 2)])
    else $error("cancel bit stayed after cancellation");
endmodule : cmt_mailbox_tx_control_props

bind cmt_mailbox_tx_control cmt_mailbox_tx_control_props #(.MAILBOXES(MAILBOXES), .IDX_W(IDX_W))
  u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .engine_tx_done(engine_tx_done),
  .engine_tx_done_mailbox(engine_tx_done_mailbox), .engine_cancel_done(engine_cancel_done),
  .engine_cancel_done_mailbox(engine_cancel_done_mailbox), .tx_select_valid(tx_select_valid),
  .tx_select_mailbox(tx_select_mailbox), .cancel_pending(cancel_pending),
  .receive_enable(receive_enable));

// file: cmt_engine_model.sv
// Protocol engine model that sends or cancels waiting mailboxes
`timescale 1ns/1ps
module cmt_engine_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  latency,
  input  wire logic        tx_select_valid,
  input  wire logic [3:0]  tx_select_mailbox,
  input  wire logic [15:0] cancel_pending,
  output logic             engine_tx_done,
  output logic [3:0]       engine_tx_done_mailbox,
  output logic             engine_cancel_done,
  output logic [3:0]       engine_cancel_done_mailbox
);
  logic [7:0] cnt;
  logic [3:0] cidx;
  logic       cany;

  // Lowest cancelled mailbox
  always_comb begin
    cany = 1'b0;
    cidx = 4'h0;
    for (int i = 15; i >= 1; i--) begin
      if (cancel_pending[i]) begin
        cany = 1'b1;
        cidx = 4'(i);
      end
    end
  end

  // Cancellation first, else send the selected mailbox
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt                        <= 8'h00;
      engine_tx_done             <= 1'b0;
      engine_cancel_done         <= 1'b0;
      engine_tx_done_mailbox     <= 4'h0;
      engine_cancel_done_mailbox <= 4'h0;
    end else begin
      engine_tx_done             <= 1'b0;
      engine_cancel_done         <= 1'b0;
      engine_tx_done_mailbox     <= ~engine_tx_done_mailbox;
      engine_cancel_done_mailbox <= ~engine_cancel_done_mailbox;
      if (!(cany || tx_select_valid)) begin
        cnt <= 8'h00;
      end else if (cnt >= latency) begin
        cnt <= 8'h00;
        if (cany) begin
          engine_cancel_done         <= 1'b1;
          engine_cancel_done_mailbox <= cidx;
        end else begin
          engine_tx_done             <= 1'b1;
          engine_tx_done_mailbox     <= tx_select_mailbox;
        end
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : cmt_engine_model

// file: cmt_mailbox_tx_control_tb.sv
// Register level testbench for the CAN mailbox transmit control block
`timescale 1ns/1ps
module cmt_mailbox_tx_control_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, eng_lat;
  logic [31:0] wdata, d;
  logic [3:0]  wstrb, txm, cam, selm;
  logic [1:0]  r;
  logic        txd, cad, selv, irq;
  logic [15:0] cpend, rxen;
  int          n_errors, checked, cycles;

  cmt_mailbox_tx_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .engine_tx_done(txd),
    .engine_tx_done_mailbox(txm), .engine_cancel_done(cad), .engine_cancel_done_mailbox(cam),
    .tx_select_valid(selv), .tx_select_mailbox(selm), .cancel_pending(cpend),
    .receive_enable(rxen), .irq(irq));
  cmt_engine_model u_eng (.aclk(aclk), .aresetn(aresetn), .latency(eng_lat),
    .tx_select_valid(selv), .tx_select_mailbox(selm), .cancel_pending(cpend),
    .engine_tx_done(txd), .engine_tx_done_mailbox(txm), .engine_cancel_done(cad),
    .engine_cancel_done_mailbox(cam));

  // ----------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ----------------------------------------------------------------
  // AXI4-Lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= {16'h0000, v}; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && u_dut.s_axi_awready) awvalid <= 1'b0;
      if (wvalid && u_dut.s_axi_wready) wvalid <= 1'b0;
      if (u_dut.s_axi_bvalid && bready) begin
        r = u_dut.s_axi_bresp;
        bready <= 1'b0;
        break;
      end
    end
    // Let outputs launched by the write settle
    @(negedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && u_dut.s_axi_arready) arvalid <= 1'b0;
      if (u_dut.s_axi_rvalid && rready) begin
        d = u_dut.s_axi_rdata;
        r = u_dut.s_axi_rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask : rc
  task automatic poll(input logic [7:0] a, input logic [31:0] exp);
    for (int i = 0; i < 200; i++) begin
      rd(a);
      if (d === exp) break;
    end
  endtask : poll

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    aresetn = 1'b0; eng_lat = 8'd20; n_errors = 0; checked = 0; cycles = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(cmt_pkg::OFF_DIRECTION, 32'h0000_0100);
    rc(cmt_pkg::OFF_REQUEST, 32'h0);
    rc(cmt_pkg::OFF_CANCEL, 32'h0);
    rc(cmt_pkg::OFF_DONE, 32'h0);
    rd(8'h1c);
    check({d[31:2], r}, {30'h0, cmt_pkg::RESP_SLVERR});
    wr(8'h1c, 16'hffff, 4'h3);
    check({30'h0, r}, {30'h0, cmt_pkg::RESP_SLVERR});
    $display("test reset done");
    wr(cmt_pkg::OFF_DIRECTION, 16'hffff, 4'h2);
    rc(cmt_pkg::OFF_DIRECTION, 32'h0000_ff00);
    check({16'h0, rxen}, 32'h0000_00fe);
    wr(cmt_pkg::OFF_DIRECTION, 16'h8101, 4'h3);
    check({16'h0, rxen}, 32'h0000_0180);
    wr(cmt_pkg::OFF_REQUEST, 16'h8001, 4'h3);
    rc(cmt_pkg::OFF_REQUEST, 32'h0);
    wr(cmt_pkg::OFF_DIRECTION, 16'h0100, 4'h3);
    $display("test direction done");
    wr(cmt_pkg::OFF_REQUEST, 16'h0802, 4'h3);
    check({27'h0, selv, selm}, 32'h0000_0013);
    poll(cmt_pkg::OFF_REQUEST, 32'h0);
    check(d, 32'h0);
    rc(cmt_pkg::OFF_DONE, 32'h0000_0802);
    check({31'h0, irq}, 32'h0);
    wr(cmt_pkg::OFF_IRQ_MASK, 16'h0003, 4'h1);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    rc(cmt_pkg::OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(cmt_pkg::OFF_DONE, 16'h0800, 4'h3);
    rc(cmt_pkg::OFF_DONE, 32'h0000_0002);
    wr(cmt_pkg::OFF_DONE, 16'h0002, 4'h3);
    rc(cmt_pkg::OFF_DONE, 32'h0);
    $display("test transmit done");
    eng_lat <= 8'd200;
    wr(cmt_pkg::OFF_REQUEST, 16'h2004, 4'h3);
    wr(cmt_pkg::OFF_REQUEST, 16'h0000, 4'h3);
    rc(cmt_pkg::OFF_REQUEST, 32'h0000_2004);
    wr(cmt_pkg::OFF_CANCEL, 16'h2000, 4'h3);
    rc(cmt_pkg::OFF_CANCEL, 32'h0000_2000);
    check({16'h0, cpend}, 32'h0000_0020);
    check({27'h0, selv, selm}, 32'h0000_001a);
    eng_lat <= 8'd4;
    poll(cmt_pkg::OFF_REQUEST, 32'h0);
    check(d, 32'h0);
    rc(cmt_pkg::OFF_CANCEL, 32'h0);
    rc(cmt_pkg::OFF_ABORT, 32'h0000_2000);
    rc(cmt_pkg::OFF_DONE, 32'h0000_0004);
    check({31'h0, irq}, 32'h1);
    rc(cmt_pkg::OFF_IRQ_STATUS, 32'h3);
    wr(cmt_pkg::OFF_ABORT, 16'h2000, 4'h3);
    rc(cmt_pkg::OFF_ABORT, 32'h0);
    $display("test cancel done");
    conclude();
  end
endmodule : cmt_mailbox_tx_control_tb
